// ### core/cmaos_bank.sv
// Purpose: Measurement, phase adjust and output clock status registers
// Assumes: Engines report synchronously to core_clk; byte register port
// Notes: Sticky flags are write-one-to-clear; a set wins over a clear
`timescale 1ns/100ps
`include "cmaos_params.svh"

module cmaos_bank (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire cmaos_pkg::cmaos_req_t req,
	input wire logic req_valid,
	output logic [7:0] rdata,
	output logic rdata_valid,
	input wire cmaos_pkg::cmaos_measure_t measure,
	input wire cmaos_pkg::cmaos_adj_t adj,
	input wire cmaos_pkg::cmaos_out_t [2:0] outs,
	input wire logic [2:0] slow_clock_status_en,
	output logic measure_summary,
	output logic adj_summary,
	output logic [2:0] out_summary
);
	import cmaos_pkg::*;

	localparam int N = `CMAOS_NUM_OUT;
	// Reset image of the adjust register; only its done bit is stored
	localparam logic [7:0] ADJ_RST = `CMAOS_ADJ_RESET;

	// Stored state
	logic [10:0] phase_offset_result_q;
	logic measure_overflow_flag_q;
	logic measure_ready_flag_q;
	logic measure_ready_irq_en_q;
	logic adjust_done_flag_q;
	logic adjust_done_irq_en_q;
	logic [N-1:0] slow_edge_flag_q;
	logic [N-1:0] slow_edge_irq_en_q;
	logic [N-1:0] restart_flag_q;
	logic [N-1:0] restart_irq_en_q;
	logic [N-1:0] halt_flag_q;
	logic [N-1:0] halt_irq_en_q;
	logic [N-1:0] slow_prev_q;
	logic [N-1:0] halted_prev_q;
	logic adj_done_prev_q;
	logic [7:0] rdata_d;
	cmaos_rd_state_t rd_state_q;

	// Address decode
	wire wr_en = req_valid & req.wr;
	wire rd_en = req_valid & ~req.wr;
	wire wr_high = wr_en & (req.addr == `CMAOS_ADDR_OFFS_HIGH);
	wire wr_adj = wr_en & (req.addr == `CMAOS_ADDR_ADJ_STAT);
	wire [N-1:0] wr_out;
	assign wr_out[0] = wr_en & (req.addr == `CMAOS_ADDR_OUT1_STAT);
	assign wr_out[1] = wr_en & (req.addr == `CMAOS_ADDR_OUT2_STAT);
	assign wr_out[2] = wr_en & (req.addr == `CMAOS_ADDR_OUT3_STAT);

	// Write-one-to-clear strobes
	wire clr_over = wr_high & req.wdata[`CMAOS_HI_OVER_BIT];
	wire clr_rdy = wr_high & req.wdata[`CMAOS_HI_RDY_BIT];
	wire clr_adj = wr_adj & req.wdata[`CMAOS_ADJ_DONE_BIT];

	// Event detection; done edge avoids relatching a held done level
	wire adj_done_evt = adj.done & ~adj_done_prev_q;
	wire [N-1:0] live;
	wire [N-1:0] slow_lvl;
	wire [N-1:0] halted_lvl;
	wire [N-1:0] slow_rise;
	wire [N-1:0] halt_evt;
	wire [N-1:0] resume_evt;
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_evt
			assign live[gi] = outs[gi].path_live;
			assign slow_lvl[gi] = outs[gi].slow_clock;
			assign halted_lvl[gi] = live[gi] & outs[gi].halted;
			assign slow_rise[gi] = live[gi] & slow_lvl[gi] & ~slow_prev_q[gi];
			assign halt_evt[gi] = halted_lvl[gi] & ~halted_prev_q[gi];
			assign resume_evt[gi] = ~halted_lvl[gi] & halted_prev_q[gi];
		end
	endgenerate

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_offset_result_q <= 11'h000;
		end else if (measure.done) begin
			phase_offset_result_q <= measure.result;
		end
	end

	// overflow and ready stickies, set beats clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			measure_overflow_flag_q <= 1'b0;
			measure_ready_flag_q <= 1'b0;
		end else begin
			measure_overflow_flag_q <= (measure.done & measure.overflow) |
				(measure_overflow_flag_q & ~clr_over);
			measure_ready_flag_q <= measure.done |
				(measure_ready_flag_q & ~clr_rdy);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			adjust_done_flag_q <= ADJ_RST[`CMAOS_ADJ_DONE_BIT];
			adj_done_prev_q <= 1'b0;
		end else begin
			adjust_done_flag_q <= adj_done_evt |
				(adjust_done_flag_q & ~clr_adj);
			adj_done_prev_q <= adj.done;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			measure_ready_irq_en_q <= 1'b0;
			adjust_done_irq_en_q <= 1'b0;
		end else begin
			if (wr_high) begin
				measure_ready_irq_en_q <= req.wdata[`CMAOS_HI_RDY_EN_BIT];
			end
			if (wr_adj) begin
				adjust_done_irq_en_q <= req.wdata[`CMAOS_ADJ_IE_BIT];
			end
		end
	end

	// Per-output stickies and enables
	generate
		for (gi = 0; gi < N; gi++) begin : g_out
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					slow_edge_flag_q[gi] <= 1'b0;
					restart_flag_q[gi] <= 1'b0;
					halt_flag_q[gi] <= 1'b0;
					slow_prev_q[gi] <= 1'b0;
					halted_prev_q[gi] <= 1'b0;
					slow_edge_irq_en_q[gi] <= 1'b0;
					restart_irq_en_q[gi] <= 1'b0;
					halt_irq_en_q[gi] <= 1'b0;
				end else begin
					slow_edge_flag_q[gi] <= slow_rise[gi] | (slow_edge_flag_q[gi]
						& ~(wr_out[gi] & req.wdata[`CMAOS_OC_SLOWF_BIT]));
					restart_flag_q[gi] <= resume_evt[gi] | (restart_flag_q[gi]
						& ~(wr_out[gi] & req.wdata[`CMAOS_OC_RSTF_BIT]));
					halt_flag_q[gi] <= halt_evt[gi] | (halt_flag_q[gi]
						& ~(wr_out[gi] & req.wdata[`CMAOS_OC_HALTF_BIT]));
					slow_prev_q[gi] <= slow_lvl[gi];
					halted_prev_q[gi] <= halted_lvl[gi];
					if (wr_out[gi]) begin
						slow_edge_irq_en_q[gi] <= req.wdata[`CMAOS_OC_SLOWIE_BIT];
						restart_irq_en_q[gi] <= req.wdata[`CMAOS_OC_RSTIE_BIT];
						halt_irq_en_q[gi] <= req.wdata[`CMAOS_OC_HALTIE_BIT];
					end
				end
			end
		end
	endgenerate

	assign measure_summary = measure_ready_flag_q & measure_ready_irq_en_q;
	assign adj_summary = adjust_done_flag_q & adjust_done_irq_en_q;
	assign out_summary = (slow_edge_flag_q & slow_edge_irq_en_q) |
		(restart_flag_q & restart_irq_en_q) |
		(halt_flag_q & halt_irq_en_q);

	// Read images; busy, result split
	wire [7:0] img_high = {1'b0, measure_overflow_flag_q,
		measure_ready_irq_en_q, measure_ready_flag_q, measure.busy,
		phase_offset_result_q[10:8]};
	wire [7:0] img_low = phase_offset_result_q[7:0];
	// adjust busy, armed; bit 7 reads one as at reset
	wire [7:0] img_adj = {1'b1, 3'h0, adjust_done_irq_en_q,
		adjust_done_flag_q, adj.busy, adj.armed};
	wire [7:0] img_out [N];
	generate
		for (gi = 0; gi < N; gi++) begin : g_img
			// inverted slow level, halted cleared until live
			assign img_out[gi] = {slow_edge_irq_en_q[gi], slow_edge_flag_q[gi],
				slow_clock_status_en[gi] & ~slow_lvl[gi],
				restart_irq_en_q[gi], restart_flag_q[gi], halt_irq_en_q[gi],
				halt_flag_q[gi], halted_lvl[gi]};
		end
	endgenerate

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		case (req.addr)
			`CMAOS_ADDR_OFFS_HIGH: rdata_d = img_high;
			`CMAOS_ADDR_OFFS_LOW: rdata_d = img_low;
			`CMAOS_ADDR_ADJ_STAT: rdata_d = img_adj;
			`CMAOS_ADDR_OUT1_STAT: rdata_d = img_out[0];
			`CMAOS_ADDR_OUT2_STAT: rdata_d = img_out[1];
			`CMAOS_ADDR_OUT3_STAT: rdata_d = img_out[2];
			default: rdata_d = 8'h00;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
			rd_state_q <= CMAOS_IDLE;
		end else begin
			case (rd_state_q)
				CMAOS_IDLE: rd_state_q <= rd_en ? CMAOS_ANSWER : CMAOS_IDLE;
				CMAOS_ANSWER: rd_state_q <= rd_en ? CMAOS_ANSWER : CMAOS_IDLE;
				default: rd_state_q <= CMAOS_IDLE;
			endcase
			if (rd_en) begin
				rdata <= rdata_d;
			end
		end
	end
	assign rdata_valid = (rd_state_q == CMAOS_ANSWER);

	a_ready_sets: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		measure.done |=> measure_ready_flag_q)
		else $error("ready flag missed a completion");
	a_over_sets: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		measure.done && measure.overflow |=> measure_overflow_flag_q)
		else $error("overflow flag missed");
	a_ready_gate: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		measure.done && measure_ready_irq_en_q && !wr_high
		|=> measure_summary)
		else $error("measurement summary missed");
	a_ready_clear: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clr_rdy && !measure.done |=> !measure_ready_flag_q)
		else $error("ready flag not cleared");
	// busy bit reads the live engine state
	a_busy_live: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rd_en && (req.addr == `CMAOS_ADDR_OFFS_HIGH)
		|=> rdata[3] == $past(measure.busy))
		else $error("busy bit wrong");
	a_done_clear: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clr_adj && !adj_done_evt |=> !adjust_done_flag_q)
		else $error("done flag not cleared");
	// done sets when the engine reports completion
	a_done_sets: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$rose(adj.done) |=> adjust_done_flag_q)
		else $error("done flag missed a completion");
	a_adj_raise: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		adj_done_evt && adjust_done_irq_en_q && !wr_adj |=> adj_summary)
		else $error("adjust summary missed");
	a_adj_live: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rd_en && (req.addr == `CMAOS_ADDR_ADJ_STAT) |=>
		rdata[1] == $past(adj.busy) && rdata[0] == $past(adj.armed))
		else $error("adjust live bits wrong");
	a_slow_edge: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$rose(outs[0].slow_clock) && outs[0].path_live |=> slow_edge_flag_q[0])
		else $error("slow edge flag missed");
	// slow edge flag clears on write one
	a_slow_clear: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		wr_out[0] && req.wdata[`CMAOS_OC_SLOWF_BIT] && !slow_rise[0]
		|=> !slow_edge_flag_q[0])
		else $error("slow edge flag not cleared");
	// slow level shown inverted while enabled
	a_slow_level: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rd_en && (req.addr == `CMAOS_ADDR_OUT1_STAT)
		&& slow_clock_status_en[0]
		|=> rdata[5] == !$past(outs[0].slow_clock))
		else $error("slow level bit wrong");
	a_halt_sets: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$rose(halted_lvl[1]) |=> halt_flag_q[1])
		else $error("halt flag missed");
	// halted bit reads stopped and live
	a_halted_live: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		rd_en && (req.addr == `CMAOS_ADDR_OUT2_STAT) |=> rdata[0] ==
		($past(outs[1].halted) && $past(outs[1].path_live)))
		else $error("halted bit wrong");
	a_restart_sets: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		$fell(halted_lvl[2]) |=> restart_flag_q[2])
		else $error("restart flag missed");
	a_out_raise: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		resume_evt[2] && restart_irq_en_q[2] && !wr_out[2]
		|=> out_summary[2])
		else $error("output summary missed");
	a_result_hold: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!measure.done |=> $stable(phase_offset_result_q))
		else $error("result changed without completion");
	a_en_hold: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!wr_adj |=> $stable(adjust_done_irq_en_q))
		else $error("adjust enable changed without write");
endmodule // cmaos_bank

// ### core/cmaos_params.svh
// Purpose: Offsets, field positions and reset values of the channel status bank
// Assumes: Byte-wide registers reached at their printed offsets
// Notes: Included by the bank and the bench
`ifndef CMAOS_PARAMS_SVH
`define CMAOS_PARAMS_SVH
`define CMAOS_ADDR_OFFS_HIGH 9'h04b
`define CMAOS_ADDR_OFFS_LOW 9'h04c
`define CMAOS_ADDR_ADJ_STAT 9'h04d
`define CMAOS_ADDR_OUT1_STAT 9'h053
`define CMAOS_ADDR_OUT2_STAT 9'h054
`define CMAOS_ADDR_OUT3_STAT 9'h055
`define CMAOS_HI_OVER_BIT 6
`define CMAOS_HI_RDY_EN_BIT 5
`define CMAOS_HI_RDY_BIT 4
`define CMAOS_ADJ_IE_BIT 3
`define CMAOS_ADJ_DONE_BIT 2
`define CMAOS_OC_SLOWIE_BIT 7
`define CMAOS_OC_SLOWF_BIT 6
`define CMAOS_OC_RSTIE_BIT 4
`define CMAOS_OC_RSTF_BIT 3
`define CMAOS_OC_HALTIE_BIT 2
`define CMAOS_OC_HALTF_BIT 1
`define CMAOS_ADJ_RESET 8'h84
`define CMAOS_NUM_OUT 3
`endif

// ### core/cmaos_pkg.sv
// Purpose: Types shared by the channel status bank
// Assumes: Constants come from cmaos_params.svh
// Notes: Status inputs travel as packed structs
package cmaos_pkg;
	// Measurement engine report
	typedef struct packed {
		logic busy;
		logic done;
		logic overflow;
		logic [10:0] result;
	} cmaos_measure_t;
	// Phase adjust engine report
	typedef struct packed {
		logic armed;
		logic busy;
		logic done;
	} cmaos_adj_t;
	// One output clock path report
	typedef struct packed {
		logic slow_clock;
		logic halted;
		logic path_live;
	} cmaos_out_t;
	// Register port request
	typedef struct packed {
		logic wr;
		logic [8:0] addr;
		logic [7:0] wdata;
	} cmaos_req_t;
	// Bank read answer states
	typedef enum logic [1:0] {
		CMAOS_IDLE = 2'b01,
		CMAOS_ANSWER = 2'b10
	} cmaos_rd_state_t;
endpackage

// ### tb/cmaos_bank_bench.sv
// Purpose: Self-checking bench for the channel status bank
// Assumes: Reads answer on the taken edge and are sampled 1 ns later
// Notes: Results drawn from a fixed seed, boundary values forced
`timescale 1ns/100ps
`include "cmaos_params.svh"
module cmaos_bank_bench;
	import cmaos_pkg::*;
	logic core_clk, reset_n, req_valid, rdata_valid;
	cmaos_req_t req;
	logic [7:0] rdata;
	cmaos_measure_t measure;
	cmaos_adj_t adj;
	cmaos_out_t [2:0] outs;
	logic [2:0] slow_clock_status_en, out_summary;
	logic measure_summary, adj_summary, ov, ie;
	logic [10:0] res;
	logic [7:0] exp8;
	logic [8:0] oa;
	int bad_count, checks_done;

	cmaos_bank u_cmaos_bank (
		.core_clk(core_clk), .reset_n(reset_n), .req(req),
		.req_valid(req_valid), .rdata(rdata), .rdata_valid(rdata_valid),
		.measure(measure), .adj(adj), .outs(outs),
		.slow_clock_status_en(slow_clock_status_en),
		.measure_summary(measure_summary), .adj_summary(adj_summary),
		.out_summary(out_summary)
	);

	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Register value compare
	task check8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Single status bit compare
	task check1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Expected image of the high measurement register
	function automatic logic [7:0] high_image(input logic ov_f,
		input logic ie_f, input logic rdy_f, input logic busy_f,
		input logic [2:0] top_f);
		return {1'b0, ov_f, ie_f, rdy_f, busy_f, top_f};
	endfunction

	// One register access; strobe drops on the taken edge
	task acc(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{wr: w, addr: a, wdata: d};
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		#1;
	endtask

	// Read and compare, answer sampled once settled
	task rd(input logic [8:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		check1(rdata_valid, 1'b1);
		check8(rdata, e);
	endtask

	task results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the few hundred cycles of tests
	initial begin
		#50000;
		bad_count++;
		results();
	end

	initial begin
		reset_n = 1'b0;
		req = '0;
		req_valid = 1'b0;
		measure = '0;
		adj = '0;
		outs = '0;
		slow_clock_status_en = '0;
		bad_count = 0;
		checks_done = 0;
		res = '0;
		void'($urandom(32'h98d1));
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(`CMAOS_ADDR_OFFS_HIGH, 8'h00);
		rd(`CMAOS_ADDR_ADJ_STAT, `CMAOS_ADJ_RESET);
		rd(9'h1ff, 8'h00);
		check1(adj_summary, 1'b0);
		// Measurements: extremes of the signed range first, then random
		for (int i = 0; i < 6; i++) begin
			ie = 1'(i);
			acc(1'b1, `CMAOS_ADDR_OFFS_HIGH, {2'b01, ie, 5'b10000});
			@(posedge core_clk);
			measure <= '{busy: 1'b1, default: '0};
			exp8 = high_image(1'b0, ie, 1'b0, 1'b1, res[10:8]);
			rd(`CMAOS_ADDR_OFFS_HIGH, exp8);
			res = (i == 0) ? 11'h3ff : (i == 1) ? 11'h400 : 11'($urandom);
			ov = (i == 2) ? 1'b1 : 1'($urandom);
			@(posedge core_clk);
			measure <= '{busy: 1'b0, done: 1'b1, overflow: ov, result: res};
			@(posedge core_clk);
			// Input cleared so a pass-through result shows up
			measure <= '0;
			exp8 = high_image(ov, ie, 1'b1, 1'b0, res[10:8]);
			rd(`CMAOS_ADDR_OFFS_HIGH, exp8);
			// Low byte read only once busy has dropped and ready is up
			rd(`CMAOS_ADDR_OFFS_LOW, res[7:0]);
			check1(measure_summary, ie);
			acc(1'b1, `CMAOS_ADDR_OFFS_HIGH, {2'b01, ie, 5'b11000});
			exp8 = high_image(1'b0, ie, 1'b0, 1'b0, res[10:8]);
			rd(`CMAOS_ADDR_OFFS_HIGH, exp8);
			check1(measure_summary, 1'b0);
		end
		// Adjust sequencer: armed, busy, done, gating and clearing
		acc(1'b1, `CMAOS_ADDR_ADJ_STAT, 8'h0f);
		rd(`CMAOS_ADDR_ADJ_STAT, 8'h88);
		check1(adj_summary, 1'b0);
		@(posedge core_clk);
		adj <= '{armed: 1'b1, busy: 1'b0, done: 1'b0};
		rd(`CMAOS_ADDR_ADJ_STAT, 8'h89);
		@(posedge core_clk);
		adj <= '{armed: 1'b0, busy: 1'b1, done: 1'b0};
		// Busy is polled here rather than trusting the done flag
		rd(`CMAOS_ADDR_ADJ_STAT, 8'h8a);
		@(posedge core_clk);
		adj <= '{armed: 1'b0, busy: 1'b0, done: 1'b1};
		rd(`CMAOS_ADDR_ADJ_STAT, 8'h8c);
		check1(adj_summary, 1'b1);
		acc(1'b1, `CMAOS_ADDR_ADJ_STAT, 8'h00);
		check1(adj_summary, 1'b0);
		acc(1'b1, `CMAOS_ADDR_ADJ_STAT, 8'h04);
		rd(`CMAOS_ADDR_ADJ_STAT, 8'h80);
		@(posedge core_clk);
		adj <= '0;
		// Output clock paths, one after another
		for (int i = 0; i < 3; i++) begin
			oa = `CMAOS_ADDR_OUT1_STAT + 9'(i);
			@(posedge core_clk);
			outs[i] <= '{slow_clock: 1'b0, halted: 1'b0, path_live: 1'b1};
			slow_clock_status_en[i] <= 1'b1;
			acc(1'b1, oa, 8'h4a);
			rd(oa, 8'h20);
			@(posedge core_clk);
			outs[i].slow_clock <= 1'b1;
			rd(oa, 8'h40);
			check1(out_summary[i], 1'b0);
			acc(1'b1, oa, 8'hb5);
			rd(oa, 8'hd4);
			check1(out_summary[i], 1'b1);
			@(posedge core_clk);
			outs[i].halted <= 1'b1;
			rd(oa, 8'hd7);
			@(posedge core_clk);
			outs[i].halted <= 1'b0;
			rd(oa, 8'hde);
			acc(1'b1, oa, 8'h4a);
			rd(oa, 8'h00);
			check1(out_summary[i], 1'b0);
		end
		results();
	end
endmodule // cmaos_bank_bench
